//--- pkg/notify_pkg.sv
// Constants and carriers for the channel device notification block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
//
// Notes on behaviour
// - Queues use classic or adapter interrupts, never both
// - Config changes always use classic interrupt path
// - Queue indicator command records 64-bit word address
// - Queue indicator command rejected after two-stage setup
// - Config indicator command records 64-bit address
// - Two-stage: shared summary byte plus queue bits
// - Two-stage payload is 25 packed big-endian bytes
// - Adapter queue bits numbered from MSB of first byte
// - Adapter subclass may differ from subchannel subclass
// - Legacy device rejects two-stage setup as unknown
// - Setup command chosen selects notification scheme
// - Classic: set bit, interrupt only if none pending
// - Config change sets bit 0, classic interrupt; the code ORs 0x80 into the first byte
// - Adapter: set queue bit, summary 0x01, interrupt
// - Adapter interrupt only if summary was clear
// - Ignore upper 32 bits of general register 2
// - Kick may return 64-bit host cookie
// - Device reset command returns to reset state
// - Unsupported command gets unit check, command reject
package notify_pkg;

  localparam logic [7:0]  CMD_SET_QUEUE_IND  = 8'h43;
  localparam logic [7:0]  CMD_SET_CONFIG_IND = 8'h53;
  localparam logic [7:0]  CMD_SET_TWO_STAGE  = 8'h73;
  localparam logic [7:0]  CMD_DEVICE_RESET   = 8'h33;
  localparam logic [11:0] DIAG_CODE          = 12'h500;
  localparam logic [3:0]  DIAG_SUBCODE_KICK  = 4'h3;
  localparam int          TWO_STAGE_BYTES    = 25;
  localparam int          ADDR_BYTES         = 8;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_QIND_LO   = 8'h08;
  localparam logic [7:0] OFF_QIND_HI   = 8'h0C;
  localparam logic [7:0] OFF_CIND_LO   = 8'h10;
  localparam logic [7:0] OFF_CIND_HI   = 8'h14;
  localparam logic [7:0] OFF_SUM_LO    = 8'h18;
  localparam logic [7:0] OFF_SUM_HI    = 8'h1C;
  localparam logic [7:0] OFF_AREA_LO   = 8'h20;
  localparam logic [7:0] OFF_AREA_HI   = 8'h24;
  localparam logic [7:0] OFF_FBIT_LO   = 8'h28;
  localparam logic [7:0] OFF_FBIT_HI   = 8'h2C;
  localparam logic [7:0] OFF_ISC       = 8'h30;
  localparam logic [7:0] OFF_COOKIE_LO = 8'h34;
  localparam logic [7:0] OFF_COOKIE_HI = 8'h38;
  localparam logic [7:0] OFF_KICK      = 8'h3C;

  // CTRL fields
  localparam int CTRL_LEGACY_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [63:0] COOKIE_SEED = 64'h0000_0000_0000_0001;

  typedef enum logic [1:0] {MODE_NONE, MODE_CLASSIC, MODE_ADAPTER} notify_mode_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic [7:0]  length;
    logic [7:0]  data;
  } cmd_beat_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [63:0] addr;
    logic [7:0]  mask;
  } mem_req_t;

endpackage

//--- design/notify_ctrl.sv
// Notification controller for a channel-attached virtual device.
// Commands arrive as byte beats; guest memory is reached by a byte-wide
// atomic OR port; software observes and steers over APB.
`timescale 1ns/1ps

module notify_ctrl
  import notify_pkg::*;
(
  input  wire logic                   CLK_SYS_IN,
  input  wire logic                   SRST_IN,
  input  wire logic                   PSEL_IN,
  input  wire logic                   PENABLE_IN,
  input  wire logic                   PWRITE_IN,
  input  wire logic [7:0]             PADDR_IN,
  input  wire logic [31:0]            PWDATA_IN,
  output logic      [31:0]            PRDATA_OUT,
  output logic                        PREADY_OUT,
  output logic                        PSLVERR_OUT,
  input  wire notify_pkg::cmd_beat_t  CMD_BEAT_IN,
  input  wire logic                   CMD_LAST_IN,
  output logic                        CMD_DONE_OUT,
  output logic                        CMD_REJECT_OUT,
  input  wire logic                   QUEUE_EVENT_IN,
  input  wire logic [15:0]            QUEUE_NUM_IN,
  input  wire logic                   CONFIG_EVENT_IN,
  input  wire logic                   SUBCH_INT_PENDING_IN,
  output notify_pkg::mem_req_t        MEM_REQ_OUT,
  output logic      [7:0]             MEM_OR_DATA_OUT,
  input  wire logic                   MEM_ACK_IN,
  input  wire logic [7:0]             MEM_OLD_DATA_IN,
  output logic                        IO_INT_OUT,
  output logic                        ADAPTER_INT_OUT,
  output logic      [7:0]             ADAPTER_ISC_OUT,
  output logic                        KICK_OUT,
  output logic      [15:0]            KICK_SUBCH_OUT,
  output logic      [15:0]            KICK_QUEUE_OUT
);
  import notify_pkg::*;

  typedef enum {ST_IDLE, ST_CONF_BIT, ST_Q_BIT, ST_SUMMARY, ST_SIGNAL} note_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // State
  notify_mode_t  mode_r;
  logic [63:0]   qind_addr_r, cind_addr_r, sum_addr_r, area_addr_r, fbit_r;
  logic [7:0]    isc_r;
  logic [31:0]   ctrl_r;
  logic [63:0]   cookie_r;
  logic [199:0]  payload_r;
  logic [7:0]    beat_cnt_r;
  logic [7:0]    cur_cmd_r;
  logic          in_cmd_r;
  note_state_t   st_r;
  logic          q_pend_r, c_pend_r;
  logic [15:0]   q_pend_num_r;
  logic          sum_was_set_r;
  logic          sig_classic_r, sig_adapter_r;
  logic          kick_seen_r;
  logic [63:0]   kick_r1_r, kick_r2_r, kick_r3_r, kick_r4_r;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire legacy      = ctrl_r[CTRL_LEGACY_BIT];
  wire beat_first  = CMD_BEAT_IN.valid && !in_cmd_r;
  wire [7:0] code  = beat_first ? CMD_BEAT_IN.code : cur_cmd_r;
  wire is_qind     = code == CMD_SET_QUEUE_IND;
  wire is_cind     = code == CMD_SET_CONFIG_IND;
  wire is_two      = (code == CMD_SET_TWO_STAGE) && !legacy;
  wire is_reset    = code == CMD_DEVICE_RESET;
  wire known       = is_qind || is_cind || is_two || is_reset;
  wire mode_clash  = (is_qind && mode_r == MODE_ADAPTER)
                  || (is_two && mode_r == MODE_CLASSIC);
  wire [7:0] need  = is_two ? 8'(TWO_STAGE_BYTES) : (is_reset ? 8'd0 : 8'(ADDR_BYTES));
  wire [7:0] got   = beat_first ? 8'd1 : beat_cnt_r + 8'd1;
  wire cmd_end     = CMD_BEAT_IN.valid && CMD_LAST_IN;
  wire short_data  = got < need && !is_reset;
  wire cmd_ok      = cmd_end && known && !mode_clash && !short_data;
  wire cmd_bad     = cmd_end && !cmd_ok;
  wire [199:0] pay = {payload_r[191:0], CMD_BEAT_IN.data};
  // Extra trailing bytes shift past the end; keep the first need bytes when 25 or fewer arrive
  wire [199:0] pay_al = pay >> (8 * (got - need));
  wire dev_reset   = SRST_IN || (cmd_ok && is_reset);

  //////////////////////////////////////////////////////////////////////////////
  // Command capture
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      in_cmd_r   <= 1'b0;
      cur_cmd_r  <= 8'h00;
      beat_cnt_r <= 8'h00;
      payload_r  <= '0;
    end else if (CMD_BEAT_IN.valid) begin
      in_cmd_r   <= !CMD_LAST_IN;
      cur_cmd_r  <= code;
      beat_cnt_r <= (got == 8'hFF) ? got : got;
      payload_r  <= pay;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      CMD_DONE_OUT   <= 1'b0;
      CMD_REJECT_OUT <= 1'b0;
    end else begin
      CMD_DONE_OUT   <= cmd_ok;
      CMD_REJECT_OUT <= cmd_bad;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (dev_reset) begin
      mode_r      <= MODE_NONE;
      qind_addr_r <= '0;
      cind_addr_r <= '0;
      sum_addr_r  <= '0;
      area_addr_r <= '0;
      fbit_r      <= '0;
      isc_r       <= '0;
    end else if (cmd_ok && is_qind) begin
      qind_addr_r <= pay_al[63:0];
      mode_r      <= MODE_CLASSIC;
    end else if (cmd_ok && is_cind) begin
      cind_addr_r <= pay_al[63:0];
    end else if (cmd_ok && is_two) begin
      sum_addr_r  <= pay_al[199:136];
      area_addr_r <= pay_al[135:72];
      fbit_r      <= pay_al[71:8];
      isc_r       <= pay_al[7:0];
      mode_r      <= MODE_ADAPTER;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Notification sequencer
  wire [63:0] qbit    = fbit_r + 64'(q_pend_num_r);
  wire [63:0] q_addr  = (mode_r == MODE_ADAPTER) ? area_addr_r + (qbit >> 3)
                                                 : qind_addr_r + 64'(7 - q_pend_num_r[5:3]);
  wire [7:0]  q_mask  = (mode_r == MODE_ADAPTER) ? (8'h80 >> qbit[2:0])
                                                 : (8'h01 << q_pend_num_r[2:0]);
  wire start_c = st_r == ST_IDLE && c_pend_r && mode_r != MODE_NONE || 
                 st_r == ST_IDLE && c_pend_r && cind_addr_r != '0;
  wire start_q = st_r == ST_IDLE && !start_c && q_pend_r && mode_r != MODE_NONE;
  wire ack     = MEM_ACK_IN && MEM_REQ_OUT.req;

  always_ff @(posedge CLK_SYS_IN) begin
    if (dev_reset) begin
      c_pend_r     <= 1'b0;
      q_pend_r     <= 1'b0;
      q_pend_num_r <= '0;
    end else begin
      c_pend_r <= CONFIG_EVENT_IN || (c_pend_r && !start_c);
      // A new event in the cycle the pending one is taken is kept, not lost
      if (QUEUE_EVENT_IN && (!q_pend_r || start_q)) begin
        q_pend_r     <= 1'b1;
        q_pend_num_r <= QUEUE_NUM_IN;
      end else if (start_q) begin
        q_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (dev_reset) begin
      st_r            <= ST_IDLE;
      MEM_REQ_OUT     <= '0;
      MEM_OR_DATA_OUT <= 8'h00;
      sum_was_set_r   <= 1'b0;
      sig_classic_r   <= 1'b0;
      sig_adapter_r   <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          sig_classic_r <= 1'b0;
          sig_adapter_r <= 1'b0;
          if (start_c) begin
            st_r            <= ST_CONF_BIT;
            MEM_REQ_OUT     <= '{req: 1'b1, write: 1'b1, addr: cind_addr_r, mask: 8'h80};
            MEM_OR_DATA_OUT <= 8'h80;
          end else if (start_q) begin
            st_r            <= ST_Q_BIT;
            MEM_REQ_OUT     <= '{req: 1'b1, write: 1'b1, addr: q_addr, mask: q_mask};
            MEM_OR_DATA_OUT <= q_mask;
          end
        end
        ST_CONF_BIT: if (ack) begin
          MEM_REQ_OUT.req <= 1'b0;
          sig_classic_r   <= 1'b1;
          st_r            <= ST_SIGNAL;
        end
        ST_Q_BIT: if (ack) begin
          if (mode_r == MODE_ADAPTER) begin
            MEM_REQ_OUT     <= '{req: 1'b1, write: 1'b1, addr: sum_addr_r, mask: 8'hFF};
            MEM_OR_DATA_OUT <= 8'h01;
            st_r            <= ST_SUMMARY;
          end else begin
            MEM_REQ_OUT.req <= 1'b0;
            sig_classic_r   <= 1'b1;
            st_r            <= ST_SIGNAL;
          end
        end
        ST_SUMMARY: if (ack) begin
          MEM_REQ_OUT.req <= 1'b0;
          sum_was_set_r   <= MEM_OLD_DATA_IN != 8'h00;
          sig_adapter_r   <= MEM_OLD_DATA_IN == 8'h00;
          st_r            <= ST_SIGNAL;
        end
        ST_SIGNAL: begin
          sig_classic_r <= 1'b0;
          sig_adapter_r <= 1'b0;
          st_r          <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (dev_reset) begin
      IO_INT_OUT      <= 1'b0;
      ADAPTER_INT_OUT <= 1'b0;
      ADAPTER_ISC_OUT <= 8'h00;
    end else begin
      IO_INT_OUT      <= sig_classic_r && st_r == ST_SIGNAL && !SUBCH_INT_PENDING_IN;
      ADAPTER_INT_OUT <= sig_adapter_r && st_r == ST_SIGNAL;
      ADAPTER_ISC_OUT <= isc_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave and diagnose kick
  wire apb_acc  = PSEL_IN && PENABLE_IN && PREADY_OUT;
  wire apb_wr   = apb_acc && PWRITE_IN;
  wire kick_go  = apb_wr && PADDR_IN == OFF_KICK;
  wire kick_ok  = kick_go && kick_r1_r[3:0] == DIAG_SUBCODE_KICK;
  wire [63:0] cookie_nxt = cookie_r + COOKIE_SEED;
  wire addr_ok  = PADDR_IN[1:0] == 2'b00 && PADDR_IN <= OFF_KICK;

  logic [31:0] rd_r;
  logic        rdy_r, err_r;
  wire  [31:0] rd_nxt =
      PADDR_IN == OFF_CTRL      ? ctrl_r :
      PADDR_IN == OFF_STATUS    ? {25'h0, sum_was_set_r, q_pend_r, c_pend_r,
                                   3'(st_r), mode_r[0]} :
      PADDR_IN == OFF_QIND_LO   ? qind_addr_r[31:0]  :
      PADDR_IN == OFF_QIND_HI   ? qind_addr_r[63:32] :
      PADDR_IN == OFF_CIND_LO   ? cind_addr_r[31:0]  :
      PADDR_IN == OFF_CIND_HI   ? cind_addr_r[63:32] :
      PADDR_IN == OFF_SUM_LO    ? sum_addr_r[31:0]   :
      PADDR_IN == OFF_SUM_HI    ? sum_addr_r[63:32]  :
      PADDR_IN == OFF_AREA_LO   ? area_addr_r[31:0]  :
      PADDR_IN == OFF_AREA_HI   ? area_addr_r[63:32] :
      PADDR_IN == OFF_FBIT_LO   ? fbit_r[31:0]       :
      PADDR_IN == OFF_FBIT_HI   ? fbit_r[63:32]      :
      PADDR_IN == OFF_ISC       ? {24'h0, isc_r}     :
      PADDR_IN == OFF_COOKIE_LO ? cookie_r[31:0]     :
      PADDR_IN == OFF_COOKIE_HI ? cookie_r[63:32]    : 32'h0000_0000;

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      ctrl_r    <= CTRL_RESET;
      kick_r1_r <= '0;
      kick_r2_r <= '0;
      kick_r3_r <= '0;
      kick_r4_r <= '0;
      cookie_r  <= '0;
      KICK_OUT       <= 1'b0;
      KICK_SUBCH_OUT <= '0;
      KICK_QUEUE_OUT <= '0;
    end else begin
      KICK_OUT <= kick_ok;
      if (apb_wr && PADDR_IN == OFF_CTRL) ctrl_r <= PWDATA_IN;
      if (apb_wr && PADDR_IN == OFF_COOKIE_LO) kick_r4_r[31:0] <= PWDATA_IN;
      if (apb_wr && PADDR_IN == OFF_COOKIE_HI) kick_r4_r[63:32] <= PWDATA_IN;
      if (apb_wr && PADDR_IN == OFF_FBIT_LO && st_r == ST_IDLE) kick_r2_r[31:0] <= PWDATA_IN;
      if (apb_wr && PADDR_IN == OFF_ISC) kick_r3_r[31:0] <= PWDATA_IN;
      if (apb_wr && PADDR_IN == OFF_STATUS) kick_r1_r[31:0] <= PWDATA_IN;
      if (kick_ok) begin
        KICK_SUBCH_OUT <= kick_r2_r[15:0];
        KICK_QUEUE_OUT <= kick_r3_r[15:0];
        cookie_r       <= cookie_nxt;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      rd_r  <= '0;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      rd_r  <= rd_nxt;
      rdy_r <= PSEL_IN && !PENABLE_IN;
      err_r <= PSEL_IN && !PENABLE_IN && !addr_ok;
    end
  end

  assign PRDATA_OUT  = rd_r;
  assign PREADY_OUT  = rdy_r;
  assign PSLVERR_OUT = err_r;

endmodule

//--- tb/notify_ctrl_asserts.sv
// Concurrent checks on the notification controller ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module notify_ctrl_asserts
  import notify_pkg::*;
(
  input wire logic                  CLK_SYS_IN,
  input wire logic                  SRST_IN,
  input wire logic                  PSEL_IN,
  input wire logic                  PENABLE_IN,
  input wire logic                  PREADY_OUT,
  input wire notify_pkg::cmd_beat_t CMD_BEAT_IN,
  input wire logic                  CMD_LAST_IN,
  input wire logic                  CMD_DONE_OUT,
  input wire logic                  CMD_REJECT_OUT,
  input wire logic                  SUBCH_INT_PENDING_IN,
  input wire notify_pkg::mem_req_t  MEM_REQ_OUT,
  input wire logic [7:0]            MEM_OR_DATA_OUT,
  input wire logic                  MEM_ACK_IN,
  input wire logic                  IO_INT_OUT,
  input wire logic                  ADAPTER_INT_OUT,
  input wire logic                  KICK_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);

  ////////////////////////////////////////////////////////////
  sequence last_beat;
    CMD_BEAT_IN.valid && CMD_LAST_IN;
  endsequence
  sequence apb_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence mem_wait;
    MEM_REQ_OUT.req && !MEM_ACK_IN;
  endsequence

  a_cmd_answer_once: assert property (last_beat |=> CMD_DONE_OUT ^ CMD_REJECT_OUT)
    else $error("command not answered exactly once");
  a_cmd_answer_cause: assert property ((CMD_DONE_OUT || CMD_REJECT_OUT) |->
    $past(CMD_BEAT_IN.valid && CMD_LAST_IN)) else $error("answer without last beat");
  a_apb_ready_next: assert property (apb_setup |=> PREADY_OUT)
    else $error("access phase not ready");
  a_io_not_pending: assert property (IO_INT_OUT |-> !$past(SUBCH_INT_PENDING_IN))
    else $error("io interrupt while one is pending");
  a_int_one_scheme: assert property (!(IO_INT_OUT && ADAPTER_INT_OUT))
    else $error("both interrupt kinds at once");
  a_mem_req_hold: assert property (mem_wait |=> MEM_REQ_OUT.req &&
    $stable(MEM_REQ_OUT.addr) && $stable(MEM_OR_DATA_OUT)) else $error("request dropped");
  a_or_single_bit: assert property (MEM_REQ_OUT.req |-> $onehot(MEM_OR_DATA_OUT))
    else $error("or data not one bit");
  a_reset_quiet: assert property ($fell(SRST_IN) |-> !MEM_REQ_OUT.req && !IO_INT_OUT
    && !ADAPTER_INT_OUT && !KICK_OUT) else $error("activity after reset");
  a_kick_pulse: assert property (KICK_OUT |=> !KICK_OUT)
    else $error("kick longer than one cycle");
endmodule

bind notify_ctrl notify_ctrl_asserts u_notify_ctrl_asserts (.*);

//--- tb/guest_mem.sv
// Guest memory behind the atomic byte OR port, answering promptly and slowly in turn.
// Assumes the controller holds each request until it sees the acknowledge.
`timescale 1ns/1ps

module guest_mem
  import notify_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire notify_pkg::mem_req_t req_in,
  input  wire logic [7:0]           or_data_in,
  output logic                      ack_out,
  output logic [7:0]                old_out
);
  logic [7:0] mem [logic [63:0]];
  logic [7:0] cur;
  int         wait_c;
  logic       slow;

  ////////////////////////////////////////////////////////////
  initial begin
    ack_out = 1'b0;
    old_out = 8'h00;
    wait_c  = 0;
    slow    = 1'b0;
  end

  // Old data toggles while idle so a stale byte is never mistaken for an answer
  always @(posedge clk_in) begin
    if (ack_out || !req_in.req) begin
      ack_out <= 1'b0;
      old_out <= ~old_out;
      wait_c  <= 0;
    end else if (wait_c < (slow ? 3 : 0)) begin
      wait_c  <= wait_c + 1;
      old_out <= ~old_out;
    end else begin
      cur = mem.exists(req_in.addr) ? mem[req_in.addr] : 8'h00;
      old_out <= cur;
      ack_out <= 1'b1;
      slow    <= ~slow;
      mem[req_in.addr] = cur | or_data_in;
    end
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the notification controller.
// Assumes the guest memory model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module tb;
  import notify_pkg::*;
  logic        CLK_SYS_IN, SRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
  logic [7:0]  PADDR_IN, MEM_OR_DATA_OUT, MEM_OLD_DATA_IN, ADAPTER_ISC_OUT, isc_seen;
  logic [31:0] PWDATA_IN, PRDATA_OUT;
  cmd_beat_t   CMD_BEAT_IN;
  mem_req_t    MEM_REQ_OUT;
  logic        CMD_LAST_IN, CMD_DONE_OUT, CMD_REJECT_OUT, QUEUE_EVENT_IN, CONFIG_EVENT_IN;
  logic        SUBCH_INT_PENDING_IN, MEM_ACK_IN, IO_INT_OUT, ADAPTER_INT_OUT, KICK_OUT;
  logic [15:0] QUEUE_NUM_IN, KICK_SUBCH_OUT, KICK_QUEUE_OUT, ksub, kq;
  logic [71:0] mlog[$];
  int          fail_count, checks_done, cyc, io_n, ad_n, kick_n;
  localparam logic [63:0] CA = 64'h0000_0000_0000_1000;
  localparam logic [63:0] QA = 64'h0000_0000_0000_2000;
  localparam logic [63:0] SA = 64'h0000_0000_0000_3000;
  localparam logic [63:0] AA = 64'h0000_0000_0000_4000;
  localparam logic [199:0] TWO = {SA, AA, 64'h0000_0000_0000_000A, 8'h05};

  notify_ctrl u_notify_ctrl (.*);
  guest_mem u_guest_mem (.clk_in(CLK_SYS_IN), .req_in(MEM_REQ_OUT), .or_data_in(MEM_OR_DATA_OUT),
                         .ack_out(MEM_ACK_IN), .old_out(MEM_OLD_DATA_IN));

  initial begin
    CLK_SYS_IN = 1'b0;
    forever #25 CLK_SYS_IN = ~CLK_SYS_IN;
  end

  ////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS_IN) begin
    cyc++;
    if (IO_INT_OUT) io_n++;
    if (ADAPTER_INT_OUT) begin
      ad_n++;
      isc_seen = ADAPTER_ISC_OUT;
    end
    if (KICK_OUT) begin
      kick_n++;
      ksub = KICK_SUBCH_OUT;
      kq = KICK_QUEUE_OUT;
    end
    if (MEM_REQ_OUT.req && MEM_ACK_IN) mlog.push_back({MEM_REQ_OUT.addr, MEM_OR_DATA_OUT});
    if (cyc > 3000) begin
      fail_count++;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; r holds slave error and read data from the ready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
    PSEL_IN   <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN  <= a;
    PWDATA_IN <= d;
    @(posedge CLK_SYS_IN);
    PENABLE_IN <= 1'b1;
    do begin
      @(posedge CLK_SYS_IN);
    end while (PREADY_OUT !== 1'b1);
    r = {PSLVERR_OUT, PRDATA_OUT};
    PSEL_IN    <= 1'b0;
    PENABLE_IN <= 1'b0;
    @(posedge CLK_SYS_IN);
  endtask

  task apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
    chk(72'(r[32]), 72'(a > OFF_KICK));
  endtask

  task apb_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(72'(r), 72'(exp));
  endtask

  // Bytes go out most significant first from the left end of d
  task cmd(input logic [7:0] code, input int n, input logic [199:0] d, input logic rej);
    for (int i = 0; i < n; i++) begin
      CMD_BEAT_IN <= '{1'b1, code, 8'(n), d[199-8*i -: 8]};
      CMD_LAST_IN <= (i == n - 1);
      @(posedge CLK_SYS_IN);
    end
    CMD_BEAT_IN <= '0;
    CMD_LAST_IN <= 1'b0;
    @(posedge CLK_SYS_IN);
    chk({CMD_DONE_OUT, CMD_REJECT_OUT}, {!rej, rej});
  endtask

  task ev(input logic cfg, input logic [15:0] q, input logic [23:0] exp);
    mlog.delete();
    io_n = 0;
    ad_n = 0;
    CONFIG_EVENT_IN <= cfg;
    QUEUE_EVENT_IN  <= !cfg;
    QUEUE_NUM_IN    <= q;
    @(posedge CLK_SYS_IN);
    CONFIG_EVENT_IN <= 1'b0;
    QUEUE_EVENT_IN  <= 1'b0;
    repeat (30) @(posedge CLK_SYS_IN);
    chk({8'(mlog.size()), 8'(io_n), 8'(ad_n)}, exp);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    {SRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} = '0;
    {CMD_BEAT_IN, CMD_LAST_IN, QUEUE_EVENT_IN, QUEUE_NUM_IN} = '0;
    {CONFIG_EVENT_IN, SUBCH_INT_PENDING_IN, cyc, kick_n} = '0;
    SRST_IN = 1'b1;
    repeat (4) @(posedge CLK_SYS_IN);
    SRST_IN <= 1'b0;
    @(posedge CLK_SYS_IN);
    chk({MEM_REQ_OUT.req, IO_INT_OUT, ADAPTER_INT_OUT, KICK_OUT, CMD_DONE_OUT}, 0);
    $display("test reset done");
    cmd(CMD_SET_CONFIG_IND, 8, {CA, 136'h0}, 1'b0);
    cmd(CMD_SET_QUEUE_IND, 8, {QA, 136'h0}, 1'b0);
    cmd(CMD_SET_QUEUE_IND, 4, {QA, 136'h0}, 1'b1);
    ev(1'b0, 16'h0003, 24'h01_0100);
    chk(mlog[0], {QA + 64'h7, 8'h08});
    SUBCH_INT_PENDING_IN <= 1'b1;
    ev(1'b0, 16'h0003, 24'h01_0000);
    SUBCH_INT_PENDING_IN <= 1'b0;
    ev(1'b1, 16'h0000, 24'h01_0100);
    chk(mlog[0], {CA, 8'h80});
    cmd(CMD_SET_TWO_STAGE, 25, TWO, 1'b1);
    cmd(8'h99, 1, '0, 1'b1);
    $display("test classic done");
    cmd(CMD_DEVICE_RESET, 1, '0, 1'b0);
    cmd(CMD_SET_CONFIG_IND, 8, {CA, 136'h0}, 1'b0);
    cmd(CMD_SET_TWO_STAGE, 25, TWO, 1'b0);
    cmd(CMD_SET_QUEUE_IND, 8, {QA, 136'h0}, 1'b1);
    ev(1'b0, 16'h0002, 24'h02_0001);
    chk(mlog[0], {AA + 64'h1, 8'h08});
    chk(mlog[1], {SA, 8'h01});
    chk(isc_seen, 8'h05);
    apb_rd(OFF_ISC, 32'h0000_0005);
    apb_rd(OFF_SUM_LO, SA[31:0]);
    ev(1'b0, 16'h0002, 24'h02_0000);
    u_guest_mem.mem[SA] = 8'h00;
    ev(1'b0, 16'h0000, 24'h02_0001);
    chk(mlog[0], {AA + 64'h1, 8'h20});
    ev(1'b1, 16'h0000, 24'h01_0100);
    $display("test adapter done");
    cmd(CMD_DEVICE_RESET, 1, '0, 1'b0);
    apb_wr(OFF_CTRL, 32'h0000_0001);
    cmd(CMD_SET_TWO_STAGE, 25, TWO, 1'b1);
    apb_wr(OFF_CTRL, 32'h0000_0000);
    apb_wr(8'hF0, 32'h1234_5678);
    apb_wr(OFF_STATUS, 32'h0000_0003);
    apb_wr(OFF_FBIT_HI, 32'hFFFF_FFFF);
    apb_wr(OFF_FBIT_LO, 32'h0001_0042);
    apb_wr(OFF_ISC, 32'h0000_0007);
    apb_wr(OFF_COOKIE_LO, 32'h0000_0001);
    apb_wr(OFF_KICK, 32'h0000_0001);
    repeat (10) @(posedge CLK_SYS_IN);
    chk({8'(kick_n), ksub, kq}, {8'h01, 16'h0042, 16'h0007});
    apb_rd(OFF_COOKIE_LO, COOKIE_SEED[31:0]);
    $display("test kick done");
    test_done();
  end
endmodule
